//--- design/sfdp_pkg.sv
// Constants and types shared by the discoverable-parameter table reader
package sfdp_pkg;

  // ---------------------------------------------------------------------------
  // Serial protocol
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5a;  // Table read instruction
  localparam logic [1:0] ADDR_BYTE_LAST       = 2'h2;   // Three address bytes, 0..2
  localparam logic [1:0] DUMMY_BYTE_LAST      = 2'h0;   // One dummy byte
  localparam logic [2:0] BIT_LAST             = 3'h7;   // Eight bits to a byte
  localparam logic [7:0] FILL_BYTE            = 8'hff;  // Unmapped table bytes

  // ---------------------------------------------------------------------------
  // Header: pointer and length of the basic table
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BPT_BASE   = 8'h30;  // Basic table start
  localparam logic [7:0] BPT_LEN_DW = 8'h09;  // Length in dwords

  // ---------------------------------------------------------------------------
  // Byte 30h fields
  // ---------------------------------------------------------------------------
  localparam logic [1:0] ERASE_4K_CODE = 2'b01;   // 4 KB erase supported
  localparam logic       WRITE_GRAN    = 1'b1;    // 64 bytes or larger
  localparam logic       VSR_WEN_REQ   = 1'b0;    // Volatile status write enable
  localparam logic       VSR_WEN_SEL   = 1'b0;    // 0 picks the 50h opcode
  localparam logic [2:0] B30_UNUSED    = 3'b111;  // Fixed ones

  // ---------------------------------------------------------------------------
  // Byte 32h fields (dword bits 23:16)
  // ---------------------------------------------------------------------------
  localparam logic       SUP_112       = 1'b1;    // Bit 16
  localparam logic [1:0] ADDR_BYTES    = 2'b00;   // Bits 18:17, three bytes only
  localparam logic       SUP_DTR       = 1'b0;    // Bit 19
  localparam logic       SUP_122       = 1'b1;    // Bit 20
  localparam logic       SUP_144       = 1'b0;    // Bit 21
  localparam logic       SUP_114       = 1'b0;    // Bit 22
  localparam logic       B32_UNUSED    = 1'b1;    // Bit 23

  // ---------------------------------------------------------------------------
  // Fast read wait states, mode bits and opcodes
  // ---------------------------------------------------------------------------
  localparam logic [4:0] WAIT_NONE     = 5'h00;   // No wait states; also used by the supported 1-2-2 mode
  localparam logic [2:0] MODE_NONE     = 3'h0;
  localparam logic [4:0] WAIT_112      = 5'h08;
  localparam logic [7:0] OPC_112       = 8'h3b;
  localparam logic [2:0] MODE_122      = 3'b100;
  localparam logic [7:0] OPC_122       = 8'hbb;
  localparam logic [7:0] OPC_NONE      = 8'hff;
  localparam logic       SUP_222       = 1'b0;
  localparam logic       SUP_444       = 1'b0;

  // ---------------------------------------------------------------------------
  // Sector types: exponent of the size, then erase opcode
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ERASE_4K_OPC  = 8'h20;
  localparam logic [7:0] SECT1_EXP     = 8'h0c;   // 4 KB
  localparam logic [7:0] SECT2_EXP     = 8'h0f;   // 32 KB
  localparam logic [7:0] SECT2_OPC     = 8'h52;
  localparam logic [7:0] SECT3_EXP     = 8'h10;   // 64 KB
  localparam logic [7:0] SECT3_OPC     = 8'hd8;
  localparam logic [7:0] SECT_ABSENT   = 8'h00;   // Zero exponent: no such type

  // ---------------------------------------------------------------------------
  // Read sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_CMD    = 6'b000010,
    ST_ADDR   = 6'b000100,
    ST_DUMMY  = 6'b001000,
    ST_DATA   = 6'b010000,
    ST_IGNORE = 6'b100000
  } state_type;

endpackage

//--- design/sfdp_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sfdp_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;  // First stage, read only by the second

  // Both stages reset to the idle level of the pins
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      meta   <= RESET_VAL[WIDTH-1:0];
      sync_o <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sfdp_sync

//--- design/sfdp_table_rom.sv
// Constant byte table: header and basic flash parameter dwords
`timescale 1ns/1ps
module sfdp_table_rom
  import sfdp_pkg::*;
(
  input  wire logic [7:0] addr_i,
  output logic      [7:0] data_o
);
  // Bytes outside the header and the basic table read as all ones
  always_comb
  begin
    case (addr_i)
      8'h00: data_o = 8'h53;  // Signature
      8'h01: data_o = 8'h46;
      8'h02: data_o = 8'h44;
      8'h03: data_o = 8'h50;
      8'h04: data_o = 8'h06;  // Revision
      8'h05: data_o = 8'h01;
      8'h06: data_o = 8'h01;
      8'h08: data_o = 8'h00;  // Header id
      8'h09: data_o = 8'h06;
      8'h0a: data_o = 8'h01;
      8'h0b: data_o = BPT_LEN_DW;
      8'h0c: data_o = BPT_BASE;
      8'h0d: data_o = 8'h00;
      8'h0e: data_o = 8'h00;
      8'h30: data_o = {B30_UNUSED,
                       VSR_WEN_SEL, VSR_WEN_REQ,
                       WRITE_GRAN,
                       ERASE_4K_CODE};
      8'h31: data_o = ERASE_4K_OPC;
      8'h32: data_o = {B32_UNUSED, SUP_114, SUP_144,
                       SUP_122, SUP_DTR,
                       ADDR_BYTES, SUP_112};
      8'h34: data_o = 8'hff;  // Density, 2 Mbit less one
      8'h35: data_o = 8'hff;
      8'h36: data_o = 8'h1f;
      8'h37: data_o = 8'h00;
      8'h38: data_o = {MODE_NONE, WAIT_NONE};
      8'h39: data_o = OPC_NONE;
      8'h3a: data_o = {MODE_NONE, WAIT_NONE};
      8'h3c: data_o = {MODE_NONE, WAIT_112};
      8'h3d: data_o = OPC_112;
      8'h3e: data_o = {MODE_122, WAIT_NONE};
      8'h3f: data_o = OPC_122;
      8'h40: data_o = {3'b111, SUP_444, 3'b111, SUP_222};
      8'h46: data_o = {MODE_NONE, WAIT_NONE};
      8'h4a: data_o = {MODE_NONE, WAIT_NONE};
      8'h4c: data_o = SECT1_EXP;
      8'h4d: data_o = ERASE_4K_OPC;
      8'h4e: data_o = SECT2_EXP;
      8'h4f: data_o = SECT2_OPC;
      8'h50: data_o = SECT3_EXP;
      8'h51: data_o = SECT3_OPC;
      8'h52: data_o = SECT_ABSENT;
      default: data_o = FILL_BYTE;  // Unused, opcodes 47h 4Bh 53h
    endcase
  end
endmodule // sfdp_table_rom

//--- design/sfdp_basic_param_table.sv
// Serial read port for the discoverable-parameter table
//
// Operation
// - Byte 30h bits 1:0 read 01b
// - Byte 30h bit 2 reads 1
// - Byte 30h bits 3 and 4 read 0
// - Byte 30h bits 7:5 fixed at 111b
// - Address byte count field reads 00b
// - DTR bit 19 reads 0
// - 1-1-2, 1-2-2 supported; 1-4-4, 1-1-4 not
// - Quad modes report zero waits, zero mode bits
// - 1-1-2: zero mode bits, opcode 3Bh
// - 1-2-2 mode bits 100b, byte 3Eh 80h
// - 4-4-4, 2-2-2 unsupported, fields 0, opcode FFh
// - Sector size is exponent; zero means absent
// - Sector one: 0Ch, opcode 20h
// - Sector two: 0Fh, opcode 52h
// - Sector three: 10h, opcode D8h
// - Sector four absent: 00h, FFh
// - Select, 5Ah, address, dummy, data; deselect ends
// - Header points to 30h, length nine dwords
`timescale 1ns/1ps
module sfdp_basic_param_table
  import sfdp_pkg::*;
(
  input  wire logic       sys_clk_i,            // 100 MHz system clock
  input  wire logic       srst_i,               // Synchronous reset, high
  input  wire logic       spi_sclk_i,           // Serial clock from the host
  input  wire logic       spi_cs_n_i,           // Chip select, low active
  input  wire logic       spi_mosi_i,           // Serial data in
  output logic            spi_miso_o,           // Serial data out
  output logic            spi_miso_oe_o,        // Drive enable for data out
  output logic            table_read_active_o,  // Data phase under way
  output logic      [7:0] table_addr_o,         // Next table byte address
  output logic            cmd_rejected_o        // One-cycle pulse, foreign opcode
);
  import sfdp_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------
  logic [2:0] pins_sync;   // {cs_n, sclk, mosi} after two flops
  logic       cs_n_s;      // Synchronised select
  logic       sclk_s;      // Synchronised clock
  logic       mosi_s;      // Synchronised data
  logic       sclk_prev;   // Previous synchronised clock
  logic       sclk_rise;   // Host samples input on this edge
  logic       sclk_fall;   // Device launches output on this edge

  // Select idles high, clock idles low in mode 0
  sfdp_sync #(
    .WIDTH     (3),
    .RESET_VAL (16'h0004)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .async_i   ({spi_cs_n_i, spi_sclk_i, spi_mosi_i}),
    .sync_o    (pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // Edge history on the synchronised clock only
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= sclk_s;
  end

  // Edges are ignored while deselected so stray toggles do nothing
  assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev;
  assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev;

  // ---------------------------------------------------------------------------
  // Input shifting
  // ---------------------------------------------------------------------------
  state_type  state;       // Sequencer state
  state_type  next_state;  // Next sequencer state
  logic [2:0] bit_cnt;     // Bits taken in the current byte
  logic [1:0] byte_cnt;    // Bytes taken in the current phase
  logic [6:0] in_shift;    // First seven bits of the incoming byte
  logic [7:0] in_byte;     // Completed byte, valid with byte_done
  logic       byte_done;   // Last bit of a byte sampled now
  logic       phase_end;   // Last byte of the address or dummy phase
  logic       cmd_ok;      // Incoming instruction is the table read

  assign in_byte   = {in_shift, mosi_s};
  assign byte_done = sclk_rise & (bit_cnt == BIT_LAST);
  assign cmd_ok    = (in_byte == PARAM_TABLE_READ_CMD);
  assign phase_end = (state == ST_ADDR)  ? (byte_cnt == ADDR_BYTE_LAST) :
                     (state == ST_DUMMY) ? (byte_cnt == DUMMY_BYTE_LAST) : 1'b0;

  // Bit and byte counters restart on every deselect
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || cs_n_s)
    begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 2'h0;
      in_shift <= 7'h00;
    end
    else if (sclk_rise)
    begin
      bit_cnt  <= bit_cnt + 3'h1;
      in_shift <= in_byte[6:0];
      if (byte_done)
        byte_cnt <= (phase_end || state == ST_CMD) ? 2'h0 : byte_cnt + 2'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Deselect wins over everything, so the host may end a read at any bit
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        next_state = ST_CMD;                       // Selected: first byte is opcode
      ST_CMD:
      begin
        if (byte_done)
          next_state = cmd_ok ? ST_ADDR : ST_IGNORE;
      end
      ST_ADDR:
      begin
        if (byte_done && phase_end)
          next_state = ST_DUMMY;
      end
      ST_DUMMY:
      begin
        if (byte_done && phase_end)
          next_state = ST_DATA;
      end
      ST_DATA:
        next_state = ST_DATA;                      // Streams until deselect
      ST_IGNORE:
        next_state = ST_IGNORE;                    // Foreign opcode: stay silent
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State register; select high returns to idle in one cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || cs_n_s)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ---------------------------------------------------------------------------
  // Table address and output shifter
  // ---------------------------------------------------------------------------
  logic [7:0] rd_addr;     // Address of the next byte to launch
  logic [7:0] rom_data;    // Table byte at rd_addr
  logic [7:0] out_shift;   // Byte being sent, MSB on the pin
  logic       first_load;  // End of dummy byte: launch first byte
  logic       next_load;   // Falling edge after a full byte
  logic       addr_take;   // Address byte to capture

  sfdp_table_rom u_rom (
    .addr_i (rd_addr),
    .data_o (rom_data)
  );

  assign first_load = (state == ST_DUMMY) & byte_done & phase_end;
  assign next_load  = (state == ST_DATA) & sclk_fall & (bit_cnt == 3'h0);
  // Only the last address byte matters; upper bytes are taken and dropped
  assign addr_take  = (state == ST_ADDR) & byte_done & phase_end;

  // The 8-bit address wraps, so a long read cycles through the table.
  // The first byte is loaded at the dummy's last rise and again at the
  // fall that follows; only that fall steps the address, so the first
  // byte is neither skipped nor sent twice.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      rd_addr <= 8'h00;
    else if (addr_take)
      rd_addr <= in_byte;
    else if (next_load)
      rd_addr <= rd_addr + 8'h01;
  end

  // First bit must stand before the host's first data rising edge, hence
  // the load on the dummy byte's last rising edge rather than a falling one
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      out_shift <= 8'h00;
    else if (first_load || next_load)
      out_shift <= rom_data;
    else if (state == ST_DATA && sclk_fall)
      out_shift <= {out_shift[6:0], 1'b0};
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // Reject pulse registered so it is one clean cycle wide
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      cmd_rejected_o <= 1'b0;
    else
      cmd_rejected_o <= (state == ST_CMD) & byte_done & ~cmd_ok;
  end

  assign spi_miso_o          = out_shift[7];
  assign spi_miso_oe_o       = (state == ST_DATA);
  assign table_read_active_o = (state == ST_DATA);
  assign table_addr_o        = rd_addr;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_oe_data_only: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    spi_miso_oe_o |-> (!$past(cs_n_s) && state == ST_DATA))
    else $error("data out driven outside the data phase");

  chk_deselect_ends: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    cs_n_s |=> (state == ST_IDLE && !spi_miso_oe_o))
    else $error("deselect did not end the transfer");

  chk_foreign_cmd: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_CMD && byte_done && in_byte != PARAM_TABLE_READ_CMD && !cs_n_s)
      |=> (state == ST_IGNORE && cmd_rejected_o) ##1 !cmd_rejected_o)
    else $error("foreign opcode not ignored");

  chk_addr_capture: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (addr_take && !cs_n_s) |=> (state == ST_DUMMY && rd_addr == $past(in_byte)))
    else $error("low address byte not captured");

  chk_addr_advance: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (next_load && !cs_n_s) |=> (rd_addr == $past(rd_addr) + 8'h01
                                && out_shift == $past(rom_data)))
    else $error("address did not advance after a byte");

  chk_msb_first: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_DATA && sclk_fall && bit_cnt != 3'h0)
      |=> (spi_miso_o == $past(out_shift[6])))
    else $error("data not shifted MSB first");

  chk_first_byte: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (first_load && !cs_n_s) |=> (state == ST_DATA && spi_miso_oe_o
                                 && spi_miso_o == $past(rom_data[7])))
    else $error("first byte not launched after dummy");

  chk_byte30_fields: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == BPT_BASE) |-> (rom_data[1:0] == 2'b01 && rom_data[2]
                               && rom_data[4:3] == 2'b00 && rom_data[7:5] == 3'b111))
    else $error("byte 30h fields wrong");

  chk_byte32_fields: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == 8'h32) |-> (rom_data == 8'h91))
    else $error("byte 32h support flags wrong");

  chk_header_ptr: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == 8'h0c) |-> (rom_data == 8'h30))
    else $error("header pointer not 30h");

  chk_sector_bytes: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == 8'h4c || rd_addr == 8'h52)
      |-> (rom_data == ((rd_addr == 8'h4c) ? 8'h0c : 8'h00)))
    else $error("sector size byte wrong");

  chk_reset_quiet: assert property (
    @(posedge sys_clk_i)
    srst_i |=> (state == ST_IDLE && !cmd_rejected_o && rd_addr == 8'h00))
    else $error("outputs not quiet after reset");

  chk_select_starts: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_IDLE && !cs_n_s) |=> (state == ST_CMD))
    else $error("select did not start opcode phase");

  chk_cmd_accept: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_CMD && byte_done && cmd_ok) |=> (state == ST_ADDR))
    else $error("table read opcode not accepted");

  chk_addr_three: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_ADDR && byte_done && byte_cnt != ADDR_BYTE_LAST)
      |=> (state == ST_ADDR))
    else $error("address phase ended early");

  chk_dummy_one: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_DUMMY && byte_done) |=> (state == ST_DATA))
    else $error("dummy phase not one byte");

  chk_data_holds: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_DATA && !cs_n_s) |=> (state == ST_DATA))
    else $error("data phase left while selected");

  chk_ignore_holds: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_IGNORE && !cs_n_s) |=> (state == ST_IGNORE && !spi_miso_oe_o))
    else $error("foreign opcode not held silent");

  chk_reject_once: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state != ST_CMD) |=> !cmd_rejected_o)
    else $error("reject pulse outside opcode byte");

  chk_bit_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    sclk_rise |=> (bit_cnt == $past(bit_cnt) + 3'h1))
    else $error("bit counter missed a rising edge");

  chk_miso_steady: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_DATA && !sclk_fall) |=> $stable(spi_miso_o))
    else $error("data out changed without a falling edge");

  chk_addr_steady: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (!addr_take && !next_load) |=> $stable(table_addr_o))
    else $error("table address moved without a load");

  chk_byte3e_value: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == 8'h3e) |-> (rom_data == 8'h80))
    else $error("byte 3Eh wrong");

  chk_absent_opcodes: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rd_addr == 8'h47 || rd_addr == 8'h4b || rd_addr == 8'h53) |-> (rom_data == 8'hff))
    else $error("unsupported opcode byte not FFh");

endmodule // sfdp_basic_param_table

//--- bench/sfdp_host_model.sv
// Behavioural serial host that reads the parameter table
`timescale 1ns/1ps
module sfdp_host_model
  import sfdp_pkg::*;
(
  input  wire logic sys_clk_i,  // Paces the serial clock
  input  wire logic miso_i,     // Serial data from the device
  input  wire logic miso_oe_i,  // Device drive enable
  output logic      sclk_o,     // Serial clock, idles low
  output logic      cs_n_o,     // Chip select, low active
  output logic      mosi_o      // Serial data to the device
);
  // ---------------------------------------------------------------------------
  // Receive state
  // ---------------------------------------------------------------------------
  logic [7:0] rx[$];        // Whole bytes only; a partial byte is dropped
  int         oe_gaps = 0;  // Table read data bits seen while the device was silent
  logic       last    = 1'b0;
  // Undriven line shows the inverse of the last bit, never a stale value
  wire        line    = miso_oe_i ? miso_i : ~last;

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // One mode 0 bit: 80 ns low, sample at the rise, 80 ns high
  task automatic bit_cycle(input logic out, output logic inb);
    mosi_o = out;
    repeat (8) @(negedge sys_clk_i);
    inb    = line;
    last   = line;
    sclk_o = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    sclk_o = 1'b0;
  endtask

  // Select, opcode, three address bytes, dummy, then nbits of data
  task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int nbits);
    logic [39:0] hdr;
    logic [7:0]  sh;
    logic        b;
    hdr = {op, addr, ~addr[7:0]};
    sh  = 8'h00;
    @(negedge sys_clk_i);
    cs_n_o = 1'b0;
    for (int i = 39; i >= 0; i--) bit_cycle(hdr[i], b);
    for (int i = 0; i < nbits; i++)
    begin
      // Silence in the data phase of a valid read is a fault
      if (op == PARAM_TABLE_READ_CMD && miso_oe_i !== 1'b1) oe_gaps++;
      bit_cycle(~mosi_o, b);
      sh = {sh[6:0], b};
      if (i % 8 == 7) rx.push_back(sh);
    end
    repeat (4) @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (6) @(negedge sys_clk_i);
  endtask
endmodule // sfdp_host_model

//--- bench/test_sfdp_basic_param_table.sv
// Self-checking bench for the parameter table serial reader
`timescale 1ns/1ps
module test_sfdp_basic_param_table;
  import sfdp_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------------------
  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  wire         sclk, cs_n, mosi, miso, oe, active, rej;
  wire  [7:0]  taddr;
  int          n_mismatch = 0;
  int          compares   = 0;
  int          n_rej = 0;           // Reject pulses seen
  int          n_oe  = 0;           // Cycles with the output driven
  logic [31:0] seed  = 32'h5ee333f4;
  logic [7:0]  r[$];                // Image read from 00h
  // Expected header and basic table bytes
  logic [7:0]  hdr[16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hff,
                           8'h00, 8'h06, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff};
  logic [7:0]  bpt[36] = '{8'he5, 8'h20, 8'h91, 8'hff, 8'hff, 8'hff, 8'h1f, 8'h00,
                           8'h00, 8'hff, 8'h00, 8'hff, 8'h08, 8'h3b, 8'h80, 8'hbb,
                           8'hee, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
                           8'hff, 8'hff, 8'h00, 8'hff, 8'h0c, 8'h20, 8'h0f, 8'h52,
                           8'h10, 8'hd8, 8'h00, 8'hff};

  always #5 sys_clk_i = ~sys_clk_i;

  // Count reject pulses and driven cycles as they happen
  always @(negedge sys_clk_i)
  begin
    if (rej === 1'b1) n_rej++;
    if (oe === 1'b1) n_oe++;
  end

  sfdp_host_model host (.sys_clk_i(sys_clk_i), .miso_i(miso), .miso_oe_i(oe),
                        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  sfdp_basic_param_table dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
    .table_read_active_o(active), .table_addr_o(taddr), .cmd_rejected_o(rej));

  // ---------------------------------------------------------------------------
  // Model, checks and closing
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Table byte at an address, wrapping at the top of the byte space
  function automatic logic [7:0] exp_byte(int a);
    a = a % 256;
    if (a < 16) return hdr[a];
    if (a >= 48 && a < 84) return bpt[a - 48];
    return 8'hff;
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Output must fall silent shortly after deselect
  task automatic wait_idle();
    for (int k = 0; k < 20 && oe !== 1'b0; k++) @(negedge sys_clk_i);
    chk("oe after deselect", oe, 1'b0);
    chk("active follows oe", active, oe);
    if (oe !== 1'b0) summarize();
  endtask

  // Read n bytes from address a with random upper address bytes
  task automatic read_cmp(int a, int n);
    seed = lfsr(seed);
    host.rx.delete();
    host.xfer(PARAM_TABLE_READ_CMD, {seed[15:0], a[7:0]}, n * 8);
    chk("byte count", host.rx.size(), n);
    foreach (host.rx[i]) chk("table byte", host.rx[i], exp_byte(a + i));
    chk("next address", taddr, (a + n + 1) % 256);
    wait_idle();
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    int c;
    logic [7:0] op;
    repeat (4) @(negedge sys_clk_i);
    chk("reset outputs", {oe, active, rej, taddr}, 11'h000);
    srst_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    // Whole header and basic table in one read
    read_cmp(0, 88);
    r = host.rx;
    chk("erase size", r[48][1:0], 2'b01);
    chk("write gran", r[48][2], 1'b1);
    chk("vsr enable", r[48][4:3], 2'b00);
    chk("unused 30h", r[48][7:5], 3'b111);
    chk("addr bytes", r[50][2:1], 2'b00);
    chk("dtr", r[50][3], 1'b0);
    chk("read modes", {r[50][6:4], r[50][0]}, 4'b0011);
    chk("quad fields", {r[56], r[58]}, 16'h0000);
    chk("1-1-2 fields", {r[60][7:5], r[61]}, {3'b000, 8'h3b});
    chk("1-2-2 mode", r[62], 8'h80);
    chk("2-2-2 4-4-4", {r[64][4], r[64][0], r[70], r[71]}, 18'h000ff);
    chk("4-4-4 fields", {r[74], r[75]}, 16'h00ff);
    chk("sector sizes", 32'(1) << r[80], 32'd65536);
    chk("sector one", {r[76], r[77]}, 16'h0c20);
    chk("sector two", {r[78], r[79]}, 16'h0f52);
    chk("sector three", {r[80], r[81]}, 16'h10d8);
    chk("sector four", {r[82], r[83]}, 16'h00ff);
    chk("header ptr", {r[11], r[12]}, 16'h0930);
    // Address wraps from ffh to 00h
    read_cmp(254, 4);
    // Random starts and lengths
    repeat (6)
    begin
      seed = lfsr(seed);
      read_cmp(seed[7:0], 1 + seed[9:8]);
    end
    // Abort in mid-byte, then a clean read
    host.rx.delete();
    host.xfer(PARAM_TABLE_READ_CMD, 24'h000036, 13);
    chk("partial read", host.rx.size(), 1);
    chk("partial byte", host.rx[0], 8'h1f);
    wait_idle();
    read_cmp(75, 3);
    // Foreign opcodes stay silent and pulse the reject flag once
    repeat (4)
    begin
      seed = lfsr(seed);
      op = (seed[7:0] == PARAM_TABLE_READ_CMD) ? 8'ha5 : seed[7:0];
      c = n_oe;
      n_rej = 0;
      host.xfer(op, seed[31:8], 16);
      chk("reject pulse", n_rej, 1);
      chk("silent", n_oe - c, 0);
    end
    chk("oe in data", host.oe_gaps, 0);
    summarize();
  end
endmodule // test_sfdp_basic_param_table
